// [cfg_reg.sv]
/*
 * One masked configuration register with load-on-release.
 * Assumes write strobes come from the same clock domain.
 */
`timescale 1ns/1ps
module cfg_reg #(
	parameter int         W   = 8,
	parameter logic [W-1:0] MSK = '1
) (
	// Clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_arst_n,
	// Load of power-up value
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_load_val,
	// Software write
	input  wire logic         i_wr,
	input  wire logic [W-1:0] i_wdata,
	// Stored value
	output logic      [W-1:0] o_q
);
	logic [W-1:0] q_ff;     // Stored bits
	logic [W-1:0] nxt_q;    // Next value

	// Load wins at power-up, writes touch only writable bits
	assign nxt_q = i_load ? (i_load_val & MSK) :
		i_wr ? ((i_wdata & MSK) | (q_ff & ~MSK)) : q_ff;

	// Storage
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign o_q = q_ff;
endmodule : cfg_reg

// [phase_cfg_monitor.sv]
/*
 * Current sharing monitor: flags any enabled phase far from the average.
 * Assumes phase currents are synchronous samples in amps.
 */
`timescale 1ns/1ps
module phase_cfg_monitor #(
	parameter int NPH = 6,
	parameter int IW  = 8
) (
	// Phase currents and enables
	input  wire logic [NPH*IW-1:0] i_cur,
	input  wire logic [NPH-1:0]    i_on,
	input  wire logic [7:0]        i_thr_amp,
	// Offending phases
	output logic      [NPH-1:0]    o_bad
);
	logic [IW+3:0] sum;   // Sum of phase currents
	logic [IW+3:0] avg;   // Average over phases

	// Sum all phases
	always_comb begin
		sum = '0;
		for (int k = 0; k < NPH; k++) begin
			sum = sum + (IW+4)'(i_cur[k*IW +: IW]);
		end
	end
	assign avg = sum / (IW+4)'(NPH);

	// Per phase deviation compare
	genvar g;
	generate
		for (g = 0; g < NPH; g++) begin : g_ph
			wire [IW+3:0] c = (IW+4)'(i_cur[g*IW +: IW]);
			wire [IW+3:0] d = (c > avg) ? (c - avg) : (avg - c);
			assign o_bad[g] = i_on[g] && (i_thr_amp != 8'h00) &&
				(d > (IW+4)'(i_thr_amp));
		end
	endgenerate
endmodule : phase_cfg_monitor

// [phase_cfg_pkg.sv]
/*
 * Package for the phase control configuration register bank: command
 * codes, field positions, reset values and decode tables.
 * Assumes a command-code / byte register port driven by a bus front end.
 */
package phase_cfg_pkg;

	// Command codes (register addresses)
	localparam logic [7:0] CMD_SLEW_MODE = 8'hDD;
	localparam logic [7:0] CMD_RAMP      = 8'hDE;
	localparam logic [7:0] CMD_SHED      = 8'hDF;
	localparam logic [7:0] CMD_UVLO      = 8'hE0;
	localparam logic [7:0] CMD_SHARE     = 8'hE3;
	localparam logic [7:0] CMD_MAXPH     = 8'hE4;

	// Reset values
	localparam logic [7:0]  RST_SLEW_MODE = 8'h89;
	localparam logic [7:0]  RST_RAMP      = 8'h06;
	localparam logic [7:0]  RST_SHED      = 8'h01;
	localparam logic [7:0]  RST_UVLO      = 8'h01;
	localparam logic [15:0] RST_SHARE     = 16'h0003;
	localparam logic [2:0]  RST_MAXPH     = 3'h5;

	// Writable masks per register
	localparam logic [7:0]  MASK_SLEW_MODE = 8'hFF;
	localparam logic [7:0]  MASK_RAMP      = 8'h07;
	localparam logic [7:0]  MASK_SHED      = 8'h0F;
	localparam logic [7:0]  MASK_UVLO      = 8'h03;
	localparam logic [15:0] MASK_SHARE     = 16'h0087;
	localparam logic [7:0]  MASK_MAXPH     = 8'h07;

	// Field positions
	localparam int BIT_INTERLEAVE  = 6;
	localparam int BIT_UNUSED5     = 5;
	localparam int BIT_SHED_EN     = 4;
	localparam int BIT_FLAT_LL     = 3;
	localparam int BIT_SHED_SINGLE = 3;
	localparam int BIT_SHUTOFF_SEL = 7;
	localparam int BIT_SHARE_STAT  = 3;
	localparam int BIT_VENDOR_STAT = 3;

	// Full load reference is this many times the per-phase limit
	localparam int FULL_LOAD_MULT = 4;
	// Single-phase shed threshold in percent
	localparam int SINGLE_PCT = 10;
	// Hardware phase count
	localparam int HW_PHASES = 6;

	// Slew rate in uV/us per code
	localparam logic [11:0] SLEW_UV [8] = '{12'h154, 12'h2A8, 12'h3FC,
		12'h550, 12'h6A4, 12'h7F8, 12'h94C, 12'hAB4};
	// Dual shed threshold in percent per code
	localparam logic [7:0] DUAL_PCT [8] = '{8'h0F, 8'h14, 8'h19, 8'h1E,
		8'h23, 8'h23, 8'h23, 8'h23};
	// Lockout level in 10 mV units
	localparam logic [11:0] UVLO_10MV [4] = '{12'h1A9, 12'h258, 12'h32A,
		12'h3FC};
	// Sharing threshold in amps, 0 means off
	localparam logic [7:0] SHARE_AMP [8] = '{8'h02, 8'h04, 8'h06, 8'h08,
		8'h0A, 8'h0F, 8'h14, 8'h00};

endpackage : phase_cfg_pkg

// [phase_control_config_registers.sv]
/*
 * Phase control configuration register bank with decoded outputs,
 * sharing warning, phase shutoff and phase count request check.
 * Assumes a command-code byte/word port from a bus front end on
 * i_core_clk, strap pins asynchronous, currents synchronous.
 */
// What this block does
// RULE1: Slew code decodes to eight slew rates
// RULE2: Interleave bit pairs phases 1/3,2/4,5/6; block only drives the bit out on o_interleave_select
// RULE3: Bit five unused, no behaviour effect
// RULE4: Shedding enable bit turns shedding on
// RULE5: Flat loadline bit selects zero load line
// RULE6: Ramp code decodes 20 to 200 mV
// RULE7: Written ramp overrides strapped ramp value
// RULE8: Full load is four times limit
// RULE9: Single bit allows drop below ten percent
// RULE10: Dual threshold codes 15 to 35 percent
// RULE11: Lockout level code, reset value 01
// RULE12: Sharing deviation sets status, raises alert
// RULE13: Shutoff select turns offending phase off
// RULE14: Sharing threshold code, reset value 011
// RULE15: Oversize phase request kept out, flagged
// RULE16: Phase code gives one to six
// RULE17: Reserved bits read zero, writes ignored
// RULE18: Power-up loads copy or strap first
`timescale 1ns/1ps
module phase_control_config_registers #(
	parameter int NPH = 6,
	parameter int IW  = 8
) (
	// Clock and reset
	input  wire logic           i_core_clk,
	input  wire logic           i_arst_n,
	// Register port
	input  wire logic [7:0]     i_cmd,
	input  wire logic           i_wr,
	input  wire logic           i_rd,
	input  wire logic [15:0]    i_wdata,
	output logic      [15:0]    o_rdata,
	output logic                o_rvalid,
	// Status clear
	input  wire logic           i_clr_share_stat,
	input  wire logic           i_clr_vendor_stat,
	// Power-up copies and strap
	input  wire logic [7:0]     i_nv_slew_mode,
	input  wire logic [7:0]     i_nv_shed,
	input  wire logic [7:0]     i_nv_uvlo,
	input  wire logic [15:0]    i_nv_share,
	input  wire logic [2:0]     i_limit_ramp_strap_pin,
	input  wire logic [2:0]     i_hw_phases,
	// Load sensing
	input  wire logic [NPH*IW-1:0] i_phase_cur,
	input  wire logic [15:0]    i_load_cur,
	input  wire logic [11:0]    i_phase_limit,
	// Decoded settings
	output logic                o_ready,
	output logic [11:0]         o_slew_uv_per_us,
	output logic                o_interleave_select,
	output logic                o_shedding_enable,
	output logic                o_flat_loadline_select,
	output logic [7:0]          o_ramp_mv,
	output logic [11:0]         o_input_lockout_10mv,
	output logic [2:0]          o_active_phases,
	output logic [2:0]          o_shed_target,
	output logic [NPH-1:0]      o_phase_on,
	// Status and alert
	output logic [7:0]          o_iout_status,
	output logic [7:0]          o_vendor_status_word,
	output logic                o_host_alert_out
);
	// Strap synchroniser
	logic [2:0] strap_s1_ff;
	logic [2:0] strap_s2_ff;
	// Power-up sequencing
	logic [1:0] boot_ff;
	logic       load;
	// Register values
	logic [7:0]  slew_q, ramp_q, shed_q, uvlo_q, maxph_q;
	logic [15:0] share_q;
	logic [2:0]  active_ff;
	logic [NPH-1:0] off_ff;
	logic        share_st_ff;
	logic        vend_st_ff;
	logic [15:0] rdata_ff;
	logic        rvalid_ff;
	// Write decodes
	wire w_slew  = i_wr && (i_cmd == phase_cfg_pkg::CMD_SLEW_MODE);
	wire w_ramp  = i_wr && (i_cmd == phase_cfg_pkg::CMD_RAMP);
	wire w_shed  = i_wr && (i_cmd == phase_cfg_pkg::CMD_SHED);
	wire w_uvlo  = i_wr && (i_cmd == phase_cfg_pkg::CMD_UVLO);
	wire w_share = i_wr && (i_cmd == phase_cfg_pkg::CMD_SHARE);
	wire w_maxph = i_wr && (i_cmd == phase_cfg_pkg::CMD_MAXPH);
	// Phase count request checks
	wire       req_bad = (i_wdata[2:0] > 3'h5) ||
		(i_wdata[2:0] >= i_hw_phases);                   // RULE15 RULE16
	wire       maxph_ok = w_maxph && !req_bad && o_ready;

	// Strap pins pass two flops
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_s1_ff <= 3'h0;
			strap_s2_ff <= 3'h0;
		end else begin
			strap_s1_ff <= i_limit_ramp_strap_pin;
			strap_s2_ff <= strap_s1_ff;
		end
	end

	// Boot counter: load after strap settles
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			boot_ff <= 2'h0;
		end else if (boot_ff != 2'h3) begin
			boot_ff <= boot_ff + 2'h1;
		end
	end
	assign load    = (boot_ff == 2'h2);                       // RULE18
	assign o_ready = (boot_ff == 2'h3);

	// Register instances
	cfg_reg #(.W(8), .MSK(phase_cfg_pkg::MASK_SLEW_MODE)) u_slew (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val(i_nv_slew_mode), .i_wr(w_slew && o_ready),
		.i_wdata(i_wdata[7:0]), .o_q(slew_q));
	cfg_reg #(.W(8), .MSK(phase_cfg_pkg::MASK_RAMP)) u_ramp (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val({5'h00, strap_s2_ff}),                   // RULE18
		.i_wr(w_ramp && o_ready),                             // RULE7
		.i_wdata(i_wdata[7:0]), .o_q(ramp_q));
	cfg_reg #(.W(8), .MSK(phase_cfg_pkg::MASK_SHED)) u_shed (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val(i_nv_shed), .i_wr(w_shed && o_ready),
		.i_wdata(i_wdata[7:0]), .o_q(shed_q));               // RULE17
	cfg_reg #(.W(8), .MSK(phase_cfg_pkg::MASK_UVLO)) u_uvlo (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val(i_nv_uvlo), .i_wr(w_uvlo && o_ready),
		.i_wdata(i_wdata[7:0]), .o_q(uvlo_q));
	cfg_reg #(.W(16), .MSK(phase_cfg_pkg::MASK_SHARE)) u_share (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val(i_nv_share), .i_wr(w_share && o_ready),
		.i_wdata(i_wdata), .o_q(share_q));
	cfg_reg #(.W(8), .MSK(phase_cfg_pkg::MASK_MAXPH)) u_maxph (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_load(load),
		.i_load_val({5'h00, phase_cfg_pkg::RST_MAXPH}),
		.i_wr(maxph_ok), .i_wdata(i_wdata[7:0]), .o_q(maxph_q)); // RULE15

	// Decoded settings, bit five of slew register drives nothing
	assign o_slew_uv_per_us      = phase_cfg_pkg::SLEW_UV[slew_q[2:0]]; // RULE1
	assign o_interleave_select   = slew_q[phase_cfg_pkg::BIT_INTERLEAVE]; // RULE2
	assign o_shedding_enable     = slew_q[phase_cfg_pkg::BIT_SHED_EN]; // RULE4 RULE3
	assign o_flat_loadline_select = slew_q[phase_cfg_pkg::BIT_FLAT_LL]; // RULE5
	assign o_ramp_mv = 8'h14 + {ramp_q[2:0], 4'h0} + {2'h0, ramp_q[2:0], 2'h0}
		+ ((ramp_q[2:0] == 3'h7) ? 8'h3C : 8'h14) - 8'h14;          // RULE6
	assign o_input_lockout_10mv  = phase_cfg_pkg::UVLO_10MV[uvlo_q[1:0]]; // RULE11

	// Load percentage against four times limit
	wire [17:0] full_ref = 18'(i_phase_limit) *
		18'(phase_cfg_pkg::FULL_LOAD_MULT);                   // RULE8
	wire [24:0] load_x100 = 25'(i_load_cur) * 25'd100;
	wire [7:0]  dual_pct  = phase_cfg_pkg::DUAL_PCT[shed_q[2:0]]; // RULE10
	wire below_dual   = load_x100 < (25'(full_ref) * 25'(dual_pct));
	wire below_single = load_x100 <
		(25'(full_ref) * 25'(phase_cfg_pkg::SINGLE_PCT));
	wire single_ok = shed_q[phase_cfg_pkg::BIT_SHED_SINGLE];    // RULE9

	// Shedding target phase count code
	assign o_shed_target = !o_shedding_enable ? active_ff :
		(below_single && single_ok) ? 3'h0 :                  // RULE9
		(below_dual && active_ff > 3'h1) ? 3'h1 : active_ff;  // RULE10

	// Active count takes the power-up value, then accepted requests only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			active_ff <= phase_cfg_pkg::RST_MAXPH;
		end else if (load || maxph_ok) begin
			active_ff <= load ? phase_cfg_pkg::RST_MAXPH : i_wdata[2:0]; // RULE15
		end
	end
	assign o_active_phases = active_ff;

	// Sharing monitor
	logic [NPH-1:0] bad;
	logic [NPH-1:0] en_mask;
	genvar g;
	generate
		for (g = 0; g < NPH; g++) begin : g_en
			assign en_mask[g] = (3'(g) <= o_shed_target) && !off_ff[g];
		end
	endgenerate
	phase_cfg_monitor #(.NPH(NPH), .IW(IW)) u_mon (
		.i_cur(i_phase_cur), .i_on(en_mask),
		.i_thr_amp(phase_cfg_pkg::SHARE_AMP[share_q[2:0]]),   // RULE14
		.o_bad(bad));                                         // RULE12

	// Shutoff of offending phases, sticky until reset
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			off_ff <= '0;
		end else if (!share_q[phase_cfg_pkg::BIT_SHUTOFF_SEL]) begin
			off_ff <= off_ff | bad;                           // RULE13
		end
	end
	assign o_phase_on = en_mask;

	// Sticky status, set wins over clear
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			share_st_ff <= 1'b0;
			vend_st_ff  <= 1'b0;
		end else begin
			share_st_ff <= (|bad) || (share_st_ff && !i_clr_share_stat); // RULE12
			vend_st_ff  <= (w_maxph && o_ready && req_bad) ||
				(vend_st_ff && !i_clr_vendor_stat);            // RULE15
		end
	end
	assign o_iout_status        = {4'h0, share_st_ff, 3'h0};
	assign o_vendor_status_word = {4'h0, vend_st_ff, 3'h0};
	assign o_host_alert_out     = share_st_ff || vend_st_ff;

	// Read mux, reserved bits come back zero
	wire [15:0] rmux =
		(i_cmd == phase_cfg_pkg::CMD_SLEW_MODE) ? {8'h00, slew_q} :
		(i_cmd == phase_cfg_pkg::CMD_RAMP)  ? {8'h00, ramp_q} :
		(i_cmd == phase_cfg_pkg::CMD_SHED)  ? {8'h00, shed_q} :
		(i_cmd == phase_cfg_pkg::CMD_UVLO)  ? {8'h00, uvlo_q} :
		(i_cmd == phase_cfg_pkg::CMD_SHARE) ? share_q :
		(i_cmd == phase_cfg_pkg::CMD_MAXPH) ? {8'h00, maxph_q} :
		16'h0000;                                             // RULE17

	// Read data register
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_ff  <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= i_rd;
			if (i_rd) begin
				rdata_ff <= rmux;
			end
		end
	end
	assign o_rdata  = rdata_ff;
	assign o_rvalid = rvalid_ff;

	// Assertions, all quiet while reset is low

	// Oversize request leaves count, raises flag
	a_oversize_kept: assert property (@(posedge i_core_clk) // RULE15
		disable iff (!i_arst_n) (w_maxph && o_ready && req_bad) |=>
		($stable(active_ff) && vend_st_ff && o_host_alert_out))
		else $error("oversize phase request changed count");

	// Accepted request is the new count
	a_accept_applied: assert property (@(posedge i_core_clk) // RULE16
		disable iff (!i_arst_n) maxph_ok |=>
		(active_ff == $past(i_wdata[2:0])))
		else $error("accepted phase request not applied");

	// Stored request and active count agree
	a_count_match: assert property (@(posedge i_core_clk) // RULE15
		disable iff (!i_arst_n) o_ready |-> (active_ff == maxph_q[2:0]))
		else $error("stored request differs from count");

	// Deviation sets status and alert
	a_share_alert: assert property (@(posedge i_core_clk) // RULE12
		disable iff (!i_arst_n) (|bad) |=> (o_iout_status[3] &&
		o_host_alert_out))
		else $error("sharing deviation not flagged");

	// Offending phase goes off when selected
	a_shutoff_sel: assert property (@(posedge i_core_clk) // RULE13
		disable iff (!i_arst_n)
		((|bad) && !share_q[7]) |=> ((off_ff & $past(bad)) == $past(bad)))
		else $error("offending phase not shut off");

	// Offending phase stays on when kept
	a_shutoff_kept: assert property (@(posedge i_core_clk) // RULE13
		disable iff (!i_arst_n)
		((|bad) && share_q[7]) |=> (off_ff == $past(off_ff)))
		else $error("phase shut off while kept on");

	// Host ramp write lands over the strap
	a_ramp_write: assert property (@(posedge i_core_clk) // RULE7
		disable iff (!i_arst_n) (w_ramp && o_ready) |=>
		(ramp_q == {5'h00, $past(i_wdata[2:0])}))
		else $error("ramp write lost");

	// Top ramp code breaks the step
	a_ramp_decode: assert property (@(posedge i_core_clk) // RULE6
		disable iff (!i_arst_n) (ramp_q[2:0] == 3'h7) |-> (o_ramp_mv == 8'hC8))
		else $error("ramp top code wrong");

	// Default lockout code gives 6.0 V
	a_uvlo_decode: assert property (@(posedge i_core_clk) // RULE11
		disable iff (!i_arst_n)
		(uvlo_q[1:0] == 2'h1) |-> (o_input_lockout_10mv == 12'h258))
		else $error("lockout level decode wrong");

	// No shedding while disabled
	a_shed_off: assert property (@(posedge i_core_clk) // RULE4
		disable iff (!i_arst_n) !o_shedding_enable |->
		(o_shed_target == active_ff))
		else $error("shedding acted while disabled");

	// Above the dual threshold all phases stay
	a_shed_dual: assert property (@(posedge i_core_clk) // RULE10
		disable iff (!i_arst_n) (o_shedding_enable && !below_dual) |->
		(o_shed_target == active_ff))
		else $error("phases shed above threshold");

	// Single phase only when allowed
	a_single_block: assert property (@(posedge i_core_clk) // RULE9
		disable iff (!i_arst_n) (o_shedding_enable && !shed_q[3]) |->
		(o_shed_target != 3'h0 || active_ff == 3'h0))
		else $error("dropped to one phase while forbidden");

	// Reserved stored bits stay clear
	a_reserved_zero: assert property (@(posedge i_core_clk) // RULE17
		disable iff (!i_arst_n) (ramp_q[7:3] == 5'h00 && share_q[15:8] == 8'h00
		&& shed_q[7:4] == 4'h0 && maxph_q[7:3] == 5'h00
		&& share_q[6:3] == 4'h0 && uvlo_q[7:2] == 6'h00))
		else $error("reserved bit set");

	// Byte registers read back a zero high byte
	a_read_reserved: assert property (@(posedge i_core_clk) // RULE17
		disable iff (!i_arst_n) (o_rvalid &&
		($past(i_cmd) != phase_cfg_pkg::CMD_SHARE)) |-> (o_rdata[15:8] == 8'h00))
		else $error("reserved read bits not zero");

	// Ready follows the power-up load
	a_boot_ready: assert property (@(posedge i_core_clk) // RULE18
		disable iff (!i_arst_n) load |=> o_ready)
		else $error("ready not after load");

	// Power-up load takes the synchronised strap
	a_strap_load: assert property (@(posedge i_core_clk) // RULE18
		disable iff (!i_arst_n) load |=>
		(ramp_q == {5'h00, $past(strap_s2_ff)}))
		else $error("strap not loaded into ramp");

	// Main scenarios reached
	c_bad_req: cover property (@(posedge i_core_clk) w_maxph && req_bad);
	c_good_req: cover property (@(posedge i_core_clk) maxph_ok);
	c_share: cover property (@(posedge i_core_clk) |bad);
	c_single: cover property (@(posedge i_core_clk) o_shed_target == 3'h0);
	c_shutoff: cover property (@(posedge i_core_clk) |off_ff);
endmodule : phase_control_config_registers

// [phase_control_config_registers_bench.sv]
/*
 * Self-checking bench for the phase control configuration register bank.
 * Assumes the host model drives the register port; stimulus is seeded.
 */
`timescale 1ns/1ps
module phase_control_config_registers_bench;
	// Bench state and design connections
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [15:0] wdata, rdata, load_cur, nv_share, lf, rd_val;
	logic [7:0]  cmd, nv_slew, nv_shed, nv_uvlo, iout_st, vend_st;
	logic [7:0]  ramp_mv, tmp8, pct;
	logic [11:0] phase_limit, slew, lockout;
	logic [2:0]  strap, hw_ph, act_ph, shed_tg;
	logic [47:0] phase_cur;
	logic [5:0]  phase_on;
	logic        wr, rd, rvalid, clr_sh, clr_vd, ready, ilv, shen, flat;
	logic        alert, vld, ok;
	int          error_cnt = 0;
	int          total_checks = 0;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	phase_control_config_registers dut_u (
		.i_core_clk(clk), .i_arst_n(arst_n), .i_cmd(cmd), .i_wr(wr),
		.i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
		.i_clr_share_stat(clr_sh), .i_clr_vendor_stat(clr_vd),
		.i_nv_slew_mode(nv_slew), .i_nv_shed(nv_shed),
		.i_nv_uvlo(nv_uvlo), .i_nv_share(nv_share),
		.i_limit_ramp_strap_pin(strap), .i_hw_phases(hw_ph),
		.i_phase_cur(phase_cur), .i_load_cur(load_cur),
		.i_phase_limit(phase_limit), .o_ready(ready),
		.o_slew_uv_per_us(slew), .o_interleave_select(ilv),
		.o_shedding_enable(shen), .o_flat_loadline_select(flat),
		.o_ramp_mv(ramp_mv), .o_input_lockout_10mv(lockout),
		.o_active_phases(act_ph), .o_shed_target(shed_tg),
		.o_phase_on(phase_on), .o_iout_status(iout_st),
		.o_vendor_status_word(vend_st), .o_host_alert_out(alert));

	phase_host_model host_u (
		.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
		.o_cmd(cmd), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

	// Random source
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	// Slew in uV/us: 340 a step, top code 2740
	function automatic logic [11:0] exp_slew(input logic [2:0] c);
		return (c == 3'h7) ? 12'hAB4 : 12'h154 * ({9'h000, c} + 12'h001);
	endfunction : exp_slew
	// Ramp in mVpp: 20 a step, top code 200
	function automatic logic [7:0] exp_ramp(input logic [2:0] c);
		return (c == 3'h7) ? 8'hC8 : 8'h14 * ({5'h00, c} + 8'h01);
	endfunction : exp_ramp
	// Lockout level in 10 mV units
	function automatic logic [11:0] exp_lock(input logic [1:0] c);
		return c[1] ? (c[0] ? 12'h3FC : 12'h32A) : (c[0] ? 12'h258 : 12'h1A9);
	endfunction : exp_lock
	// Six-to-two shed threshold in percent
	function automatic logic [7:0] exp_dual(input logic [2:0] c);
		return (c > 3'h3) ? 8'h23 : 8'h0F + 8'h05 * {5'h00, c};
	endfunction : exp_dual

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] exp, got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Read, then compare valid pulse and masked data
	task automatic rchk(input logic [7:0] c, input logic [15:0] e, m);
		host_u.read_reg(c, rd_val, vld);
		chk("read valid", 16'h0001, {15'h0000, vld});
		chk("read data", e, rd_val & m);
	endtask : rchk
	// Decoded slew and mode outputs against a written byte
	task automatic chk_modes(input logic [7:0] v);
		chk("slew", {4'h0, exp_slew(v[2:0])}, {4'h0, slew});
		chk("modes", {13'h0000, v[6], v[4], v[3]},
			{13'h0000, ilv, shen, flat});
	endtask : chk_modes
	// Load current change, settled at mid-cycle
	task automatic set_load(input logic [15:0] v);
		@(posedge clk);
		load_cur <= v;
		@(negedge clk);
	endtask : set_load
	// One-cycle status clear pulse
	task automatic pulse_clr(input logic sh);
		@(posedge clk);
		clr_sh <= sh;
		clr_vd <= !sh;
		@(posedge clk);
		clr_sh <= 1'b0;
		clr_vd <= 1'b0;
		@(negedge clk);
	endtask : pulse_clr
	// Make phase 2 deviate or not, then wait for the alert
	task automatic dev_ph2(input logic [7:0] v);
		@(posedge clk);
		phase_cur[23:16] <= v;
		for (int i = 0; i < 8 && alert !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
	endtask : dev_ph2

	// Verdict and end of run
	task automatic complete_run();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	// Main sequence
	initial begin
		lf = 16'h001B;
		clr_sh = 1'b0;
		clr_vd = 1'b0;
		lf = lfsr_next(lf);
		nv_slew = lf[7:0];
		nv_shed = ~lf[7:0];
		lf = lfsr_next(lf);
		nv_uvlo = {lf[7:2], 2'h1};
		strap = lf[4:2];
		nv_share = (lfsr_next(lf) & 16'hFF78) | 16'h0003;
		hw_ph = 3'h4;
		phase_cur = {6{8'h0A}};
		load_cur = 16'h0000;
		phase_limit = 12'h064;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 8 && ready !== 1'b1; i++) @(negedge clk);
		chk("ready", 16'h0001, {15'h0000, ready});
		// Power-up contents from copies and strap
		rchk(phase_cfg_pkg::CMD_SLEW_MODE, {8'h00, nv_slew & 8'hDF}, 16'hFFDF);
		chk_modes(nv_slew);
		rchk(phase_cfg_pkg::CMD_RAMP, {13'h0000, strap}, 16'hFFFF);
		chk("ramp", {8'h00, exp_ramp(strap)}, {8'h00, ramp_mv});
		rchk(phase_cfg_pkg::CMD_SHED, {12'h000, nv_shed[3:0]}, 16'hFFFF);
		rchk(phase_cfg_pkg::CMD_UVLO, 16'h0001, 16'hFFFF);
		chk("lockout", 16'h0258, {4'h0, lockout});
		rchk(phase_cfg_pkg::CMD_SHARE, 16'h0003, 16'hFFFF);
		rchk(8'h00, 16'h0000, 16'hFFFF);
		// Every slew code with random mode bits, then the spare bit flipped
		for (int c = 0; c < 8; c++) begin
			lf = lfsr_next(lf);
			tmp8 = {lf[7:3], 3'(c)};
			host_u.write_reg(phase_cfg_pkg::CMD_SLEW_MODE, {lf[15:8], tmp8});
			chk_modes(tmp8);
			host_u.write_reg(phase_cfg_pkg::CMD_SLEW_MODE, {8'h00, tmp8 ^ 8'h20});
			chk_modes(tmp8);
		end
		// Every ramp code, written over the strapped value
		for (int c = 0; c < 8; c++) begin
			lf = lfsr_next(lf);
			host_u.write_reg(phase_cfg_pkg::CMD_RAMP, {lf[15:3], 3'(c)});
			chk("ramp", {8'h00, exp_ramp(3'(c))}, {8'h00, ramp_mv});
			rchk(phase_cfg_pkg::CMD_RAMP, 16'(c), 16'hFFFF);
		end
		// Every lockout code
		for (int c = 0; c < 4; c++) begin
			lf = lfsr_next(lf);
			host_u.write_reg(phase_cfg_pkg::CMD_UVLO, {lf[15:2], 2'(c)});
			chk("lockout", {4'h0, exp_lock(2'(c))}, {4'h0, lockout});
		end
		// Phase count requests against four hardware phases
		for (int c = 0; c < 8; c++) begin
			lf = lfsr_next(lf);
			tmp8 = {5'h00, act_ph};
			ok = (c < 4);
			host_u.write_reg(phase_cfg_pkg::CMD_MAXPH, {lf[15:3], 3'(c)});
			@(negedge clk);
			chk("phases", ok ? 16'(c) : {8'h00, tmp8}, {13'h0000, act_ph});
			chk("vendor flag", {15'h0000, !ok}, {15'h0000, vend_st[3]});
			chk("alert", {15'h0000, !ok}, {15'h0000, alert});
			pulse_clr(1'b0);
		end
		@(posedge clk);
		hw_ph <= 3'h6;
		host_u.write_reg(phase_cfg_pkg::CMD_MAXPH, 16'h0005);
		rchk(phase_cfg_pkg::CMD_MAXPH, 16'h0005, 16'hFFFF);
		// Shedding on; limit 100 A makes 4 A one percent of full load
		host_u.write_reg(phase_cfg_pkg::CMD_SLEW_MODE, 16'h0010);
		for (int c = 0; c < 8; c++) begin
			lf = lfsr_next(lf);
			pct = exp_dual(3'(c));
			host_u.write_reg(phase_cfg_pkg::CMD_SHED, {lf[15:4], 1'b1, 3'(c)});
			set_load({8'h00, pct - 8'h02} * 16'h0004);
			chk("shed below", 16'h0001, {13'h0000, shed_tg});
			set_load({8'h00, pct + 8'h02} * 16'h0004);
			chk("shed above", 16'h0005, {13'h0000, shed_tg});
		end
		set_load(16'h0014);
		chk("single on", 16'h0000, {13'h0000, shed_tg});
		host_u.write_reg(phase_cfg_pkg::CMD_SHED, 16'h0000);
		chk("single off", 16'h0001, {13'h0000, shed_tg});
		host_u.write_reg(phase_cfg_pkg::CMD_SLEW_MODE, 16'h0000);
		chk("shed off", 16'h0005, {13'h0000, shed_tg});
		// Sharing warning with the phase kept on, then switched off
		host_u.write_reg(phase_cfg_pkg::CMD_SHARE, {lf[15:8], 8'hF8});
		rchk(phase_cfg_pkg::CMD_SHARE, 16'h0080, 16'hFFFF);
		dev_ph2(8'h14);
		chk("share flag", 16'h0001, {15'h0000, iout_st[3]});
		chk("alert", 16'h0001, {15'h0000, alert});
		chk("phase kept", 16'h0001, {15'h0000, phase_on[2]});
		dev_ph2(8'h0A);
		pulse_clr(1'b1);
		chk("alert clear", 16'h0000, {15'h0000, alert});
		// Codes for 10 A and 8 A against a 9 A deviation
		host_u.write_reg(phase_cfg_pkg::CMD_SHARE, 16'h0084);
		dev_ph2(8'h14);
		chk("share 10A", 16'h0000, {15'h0000, alert});
		dev_ph2(8'h0A);
		host_u.write_reg(phase_cfg_pkg::CMD_SHARE, 16'h0083);
		dev_ph2(8'h14);
		chk("share 8A", 16'h0001, {15'h0000, alert});
		dev_ph2(8'h0A);
		pulse_clr(1'b1);
		host_u.write_reg(phase_cfg_pkg::CMD_SHARE, 16'h0000);
		dev_ph2(8'h14);
		chk("phase off", 16'h0000, {15'h0000, phase_on[2]});
		complete_run();
	end
endmodule : phase_control_config_registers_bench

// [phase_host_model.sv]
/*
 * Host model for the register port: one-cycle write and read strobes.
 * Assumes the bench calls its tasks and waits for ready before writing.
 */
`timescale 1ns/1ps
module phase_host_model (
	// Clock
	input  wire logic        i_core_clk,
	// Read answer from the device
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid,
	// Register port towards the device
	output logic      [7:0]  o_cmd,
	output logic             o_wr,
	output logic             o_rd,
	output logic      [15:0] o_wdata
);
	// Idle port at time zero
	initial begin
		o_cmd   = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
		o_wdata = 16'h0000;
	end

	// Write strobe for one cycle, then settle to mid-cycle
	task automatic write_reg(input logic [7:0] cmd, input logic [15:0] d);
		@(posedge i_core_clk);
		o_cmd   <= cmd;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_core_clk);
		o_wr    <= 1'b0;
		o_wdata <= ~d; // Released data does not keep the old value
		@(negedge i_core_clk);
	endtask : write_reg

	// Read strobe; answer is taken in the cycle after the strobe
	task automatic read_reg(input logic [7:0] cmd, output logic [15:0] d,
		output logic vld);
		@(posedge i_core_clk);
		o_cmd <= cmd;
		o_rd  <= 1'b1;
		@(posedge i_core_clk);
		o_rd  <= 1'b0;
		@(negedge i_core_clk);
		d   = i_rdata;
		vld = i_rvalid;
	endtask : read_reg
endmodule : phase_host_model
